// ---- hw/usy_pkg.sv ----
package usy_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register addresses on the plain register port
    localparam int AW = 3;
    localparam int DW = 8;
    localparam logic [AW-1:0] A_CTRL = 3'h0;
    localparam logic [AW-1:0] A_CTRL2 = 3'h1;
    localparam logic [AW-1:0] A_TXD = 3'h2;
    localparam logic [AW-1:0] A_RXD = 3'h3;
    localparam logic [AW-1:0] A_STAT = 3'h4;
    localparam logic [AW-1:0] A_DIVL = 3'h5;
    localparam logic [AW-1:0] A_DIVH = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int C_EN = 0;
    localparam int C_HOST = 1;
    localparam int C_POL = 2;
    localparam int C_TRANSMIT_ENABLE = 3;
    localparam int C_SINGLE_RECEIVE_ENABLE = 4;
    localparam int C_CONTINUOUS_RECEIVE_ENABLE = 5;
    localparam int C_TX9 = 6;
    localparam int C_RX9 = 7;
    localparam int C2_TRANSMIT_NINTH_BIT = 0;
    localparam int C2_WIDE = 1;
    localparam int S_RXF = 0;
    localparam int S_OVERRUN_FLAG = 1;
    localparam int S_RECEIVE_NINTH_BIT = 2;
    localparam int S_TXE = 3;
    localparam int S_IDLE = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and counts
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DIV_RST = 8'h00;
    localparam logic [3:0] NB8 = 4'h8;
    localparam logic [3:0] NB9 = 4'h9;
    localparam logic [1:0] FIFO_DEPTH = 2'h2;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } usy_state_t;

    // One register-port request
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } usy_bus_t;

    // Whole state of the port
    typedef struct packed {
        logic [1:0] ck_s;
        logic [1:0] dt_s;
        logic ck_d;
        logic [7:0] ctrl;
        logic transmit_ninth_bit;
        logic wide;
        logic [7:0] divl;
        logic [7:0] divh;
        logic [15:0] cnt;
        logic sck;
        logic ck_oe;
        logic dout;
        logic dt_oe;
        usy_state_t st;
        logic dir_rx;
        logic [3:0] bits;
        logic [8:0] transmit_shift_register;
        logic [7:0] hold;
        logic hold_full;
        logic [8:0] receive_shift_register;
        logic [1:0][8:0] fifo;
        logic head;
        logic [1:0] fcnt;
        logic overrun_flag;
        logic [7:0] rdata;
    } usy_st_t;

endpackage : usy_pkg

// ---- hw/usy_top.sv ----
// Summary of operation
// - One shared data line, so transmit and receive never happen together.
// - No start or stop bits; only data bits are shifted.
// - Both receive enables clear means transmit; either set means receive.
// - As host the device drives the clock line, driver enabled automatically while transmit or receive is enabled.
// - Host makes one clock per data bit and no extra clocks.
// - Polarity set idles clock high; cleared idles it low.
// - Transmit bits change on the leading edge and hold until the next.
// - Receive samples the data line on the trailing edge into the shift register.
// - Host transmit drives both data and clock pins.
// - Holding write starts transfer; waits while the shift register is busy.
// - Host receive releases the data pin for the partner.
// - Single receive clocks one character then clears its own enable.
// - Continuous receive clocks until cleared; clearing mid-character drops it.
// - Both enables set: single enable clears after first character, continuous rules.
// - Finished characters enter a two-entry FIFO; flag holds while any unread.
// - Third character into a full FIFO sets overrun and blocks more characters.
// - Overrun clears by clearing continuous enable or port enable; latter resets all.
// - Nine-bit receive shifts nine bits; ninth bit of oldest shown in status.
// - As client the clock comes from the line; own clock driver off.
// - Nine-bit transmit sends a ninth bit from its own field.
// - Empty flag shows the holding register can take a byte; write clears it.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module usy_top (
    // Clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // Register port
    input wire usy_pkg::usy_bus_t BUS,
    output logic [usy_pkg::DW-1:0] RDATA,
    // Clock line pin
    input wire logic SERIAL_CLOCK_LINE_IN,
    output logic SERIAL_CLOCK_LINE_OUT,
    output logic SERIAL_CLOCK_LINE_OE,
    // Data line pin
    input wire logic SERIAL_DATA_LINE_IN,
    output logic SERIAL_DATA_LINE_OUT,
    output logic SERIAL_DATA_LINE_OE
);
    import usy_pkg::*;

    usy_st_t s;
    usy_st_t n;
    logic en, host, pol, transmit_enable, single_receive_enable, continuous_receive_enable, rx_mode, running, tick;
    logic lead, trail, done, done_rx, pop;
    logic [3:0] nb;
    logic [15:0] div;
    logic [8:0] rsr_n;
    logic [8:0] chr;
    logic [7:0] rmux;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded controls and line events
    assign en = s.ctrl[C_EN];
    assign host = s.ctrl[C_HOST];
    assign pol = s.ctrl[C_POL];
    assign transmit_enable = s.ctrl[C_TRANSMIT_ENABLE];
    assign single_receive_enable = s.ctrl[C_SINGLE_RECEIVE_ENABLE];
    assign continuous_receive_enable = s.ctrl[C_CONTINUOUS_RECEIVE_ENABLE];
    assign rx_mode = single_receive_enable | continuous_receive_enable;
    assign running = (s.st == ST_SHIFT);
    assign div = s.wide ? {s.divh, s.divl} : {8'h00, s.divl};
    assign tick = (s.cnt == 16'h0000);
    // Ninth bit is part of the character only in the chosen direction
    assign nb = (s.dir_rx ? s.ctrl[C_RX9] : s.ctrl[C_TX9]) ? NB9 : NB8;
    // Host edges come from its own divider; client edges from the synced line
    assign lead = running && (host ? (tick && s.sck == pol)
                                   : (s.ck_s[1] != s.ck_d && s.ck_s[1] != pol));
    assign trail = running && (host ? (tick && s.sck != pol)
                                    : (s.ck_s[1] != s.ck_d && s.ck_s[1] == pol));
    assign done = trail && (s.bits == nb - 4'h1);
    assign done_rx = done && s.dir_rx;
    assign pop = BUS.rd && BUS.addr == A_RXD && s.fcnt != 2'h0;
    assign rsr_n = {s.dt_s[1], s.receive_shift_register[8:1]};
    assign chr = s.ctrl[C_RX9] ? rsr_n : {1'b0, rsr_n[8:1]};

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero
    always_comb begin
        rmux = 8'h00;
        case (BUS.addr)
            A_CTRL: rmux = s.ctrl;
            A_CTRL2: rmux = {6'h00, s.wide, s.transmit_ninth_bit};
            A_RXD: rmux = s.fifo[s.head][7:0];
            A_STAT: begin
                rmux[S_RXF] = (s.fcnt != 2'h0);
                rmux[S_OVERRUN_FLAG] = s.overrun_flag;
                rmux[S_RECEIVE_NINTH_BIT] = s.fifo[s.head][8];
                rmux[S_TXE] = !s.hold_full;
                rmux[S_IDLE] = !running;
            end
            A_DIVL: rmux = s.divl;
            A_DIVH: rmux = s.divh;
            default: rmux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        n = s;
        // Both pins pass two flops; only the second is read
        n.ck_s = {s.ck_s[0], SERIAL_CLOCK_LINE_IN};
        n.dt_s = {s.dt_s[0], SERIAL_DATA_LINE_IN};
        n.ck_d = s.ck_s[1];
        n.rdata = BUS.rd ? rmux : 8'h00;

        // Software writes
        if (BUS.wr) begin
            case (BUS.addr)
                A_CTRL: begin
                    n.ctrl = BUS.wdata;
                    if (!BUS.wdata[C_CONTINUOUS_RECEIVE_ENABLE]) begin
                        n.overrun_flag = 1'b0;
                    end
                end
                A_CTRL2: begin
                    n.transmit_ninth_bit = BUS.wdata[C2_TRANSMIT_NINTH_BIT];
                    n.wide = BUS.wdata[C2_WIDE];
                end
                A_TXD: begin
                    n.hold = BUS.wdata;
                    n.hold_full = 1'b1;
                end
                A_DIVL: n.divl = BUS.wdata;
                A_DIVH: n.divh = BUS.wdata;
                default: n.cnt = s.cnt;
            endcase
        end

        // FIFO pop on a low-byte read
        if (pop) begin
            n.head = !s.head;
            n.fcnt = s.fcnt - 2'h1;
        end

        case (s.st)
            ST_IDLE: begin
                n.cnt = div;
                n.sck = pol;
                n.bits = 4'h0;
                if (en && rx_mode && !s.overrun_flag) begin
                    n.st = ST_SHIFT;
                    n.dir_rx = 1'b1;
                    n.receive_shift_register = 9'h000;
                end else if (en && !rx_mode && transmit_enable && s.hold_full) begin
                    // Idle shifter takes the held word at once
                    n.st = ST_SHIFT;
                    n.dir_rx = 1'b0;
                    n.transmit_shift_register = {s.transmit_ninth_bit, s.hold};
                    n.hold_full = BUS.wr && BUS.addr == A_TXD;
                end
            end
            ST_SHIFT: begin
                if (host) begin
                    n.cnt = tick ? div : s.cnt - 16'h0001;
                    n.sck = tick ? !s.sck : s.sck;
                end
                if (lead && !s.dir_rx) begin
                    n.dout = s.transmit_shift_register[0];
                    n.transmit_shift_register = {1'b0, s.transmit_shift_register[8:1]};
                end
                if (trail) begin
                    n.bits = s.bits + 4'h1;
                    if (s.dir_rx) begin
                        n.receive_shift_register = rsr_n;
                    end
                end
                if (done) begin
                    n.st = ST_IDLE;
                end
                if (done_rx) begin
                    n.ctrl[C_SINGLE_RECEIVE_ENABLE] = 1'b0;
                    if (n.fcnt == FIFO_DEPTH) begin
                        n.overrun_flag = 1'b1;
                    end else begin
                        // Index from the post-pop head, so a same-cycle read cannot misplace it
                        n.fifo[n.head ^ n.fcnt[0]] = chr;
                        n.fcnt = n.fcnt + 2'h1;
                    end
                end
                // Direction change stops the clock and drops the partial character
                if (s.dir_rx != rx_mode) begin
                    n.st = ST_IDLE;
                    n.sck = pol;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        // Pin drivers follow the configured direction
        n.ck_oe = en && host && (rx_mode || transmit_enable);
        n.dt_oe = en && !rx_mode && transmit_enable;

        // Port disable resets the whole serial side
        if (!n.ctrl[C_EN]) begin
            n.st = ST_IDLE;
            n.overrun_flag = 1'b0;
            n.fcnt = 2'h0;
            n.head = 1'b0;
            n.hold_full = 1'b0;
            n.bits = 4'h0;
            n.sck = n.ctrl[C_POL];
            n.ck_oe = 1'b0;
            n.dt_oe = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.divl <= DIV_RST;
            s.divh <= DIV_RST;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from flops
    assign RDATA = s.rdata;
    assign SERIAL_CLOCK_LINE_OUT = s.sck;
    assign SERIAL_CLOCK_LINE_OE = s.ck_oe;
    assign SERIAL_DATA_LINE_OUT = s.dout;
    assign SERIAL_DATA_LINE_OE = s.dt_oe;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!ARST_N);

    half_duplex_a: assert property (s.dt_oe |-> $past(!rx_mode))
        else $error("data driven while receiving");
    client_clk_off_a: assert property (!host && !BUS.wr ##1 1'b1 |-> !s.ck_oe)
        else $error("client drives clock");
    idle_clock_a: assert property (s.st == ST_IDLE && !BUS.wr |=> s.sck == $past(pol))
        else $error("clock not at idle level");
    // A control write two cycles back may move the idle level, so skip that case
    no_extra_clk_a: assert property (s.st == ST_IDLE && $past(s.st == ST_IDLE)
        && $past(!BUS.wr) && $past(!BUS.wr, 2) |-> $stable(s.sck))
        else $error("clock toggled while idle");
    tx_stable_a: assert property (running && !s.dir_rx && !lead |=> $stable(s.dout))
        else $error("data changed off leading edge");
    rx_sample_a: assert property (running && s.dir_rx && trail
        |=> s.receive_shift_register[8] == $past(s.dt_s[1]))
        else $error("sample not taken on trailing edge");
    tx_load_a: assert property (en && s.st == ST_IDLE && s.hold_full && !rx_mode && transmit_enable
        && !BUS.wr |=> s.st == ST_SHIFT && !s.hold_full)
        else $error("held word not moved to shifter");
    single_clear_a: assert property (done_rx && single_receive_enable && !BUS.wr |=> !single_receive_enable)
        else $error("single receive enable not cleared");
    abort_a: assert property (running && s.dir_rx && !rx_mode && en |=> s.st == ST_IDLE)
        else $error("receive not halted");
    overrun_a: assert property (done_rx && s.fcnt == FIFO_DEPTH && !pop && en
        |=> s.overrun_flag && s.fcnt == FIFO_DEPTH)
        else $error("overrun not flagged");
    hold_write_a: assert property (en && BUS.wr && BUS.addr == A_TXD |=> s.hold_full)
        else $error("holding register write lost");

    tx_char_c: cover property (done && !s.dir_rx);
    rx_push_c: cover property (done_rx && s.fcnt == 2'h1);
    overrun_c: cover property (s.overrun_flag && pop);
    client_rx_c: cover property (done_rx && !host);

endmodule : usy_top

`default_nettype wire

// ---- testbench/usy_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

// Far-side serial peer, purely behavioural
module usy_peer (
    // Line side
    input wire logic ck,
    input wire logic dt,
    // Bench control
    input wire logic pol,
    input wire logic drv,
    input wire logic load,
    input wire logic [8:0] word,
    // Peer results
    output logic dout,
    output logic [8:0] got
);
    logic [8:0] sh = 9'h000;
    logic b = 1'b0;

    // Preload the next word to send
    always @(posedge load) sh = word;

    // Leading edge shifts out, trailing edge samples
    always @(ck) begin
        if (ck !== pol) begin
            b = sh[0];
            sh = sh >> 1;
        end else begin
            got = {dt, got[8:1]};
        end
    end

    // Released line shows the inverse, never a stale bit
    assign dout = drv ? b : ~b;
endmodule : usy_peer

`default_nettype wire

// ---- testbench/usy_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module usy_top_tb;
    import usy_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    usy_bus_t bus = '0;
    logic [7:0] rdata;
    logic tb_ck = 1'b0;
    logic pol = 1'b0;
    logic ck_out, ck_oe, dt_out, dt_oe, p_dout;
    logic p_drv = 1'b0;
    logic p_ld = 1'b0;
    logic [8:0] p_w = 9'h000;
    logic [8:0] got;
    wire logic ck;
    wire logic dt;
    int ntr = 0;
    int err_count = 0;
    int n_checks = 0;

    // Wire levels from the DUT's pin enables; bench clock and peer data drive otherwise
    assign ck = ck_oe ? ck_out : tb_ck;
    assign dt = dt_oe ? dt_out : p_dout;

    always #2.5 clk = ~clk;
    // Trailing edges seen on the line
    always @(ck) if (ck === pol) ntr++;

    usy_top i_dut (.CLK(clk), .ARST_N(arst_n), .BUS(bus), .RDATA(rdata),
        .SERIAL_CLOCK_LINE_IN(ck), .SERIAL_CLOCK_LINE_OUT(ck_out),
        .SERIAL_CLOCK_LINE_OE(ck_oe), .SERIAL_DATA_LINE_IN(dt),
        .SERIAL_DATA_LINE_OUT(dt_out), .SERIAL_DATA_LINE_OE(dt_oe));
    usy_peer i_peer (.ck(ck), .dt(dt), .pol(pol), .drv(p_drv), .load(p_ld),
        .word(p_w), .dout(p_dout), .got(got));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // Bounded wait on one status bit
    task automatic poll(input int b);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 400 && s[b] !== 1'b1; i++) rd(A_STAT, s);
        chk("status poll", 9'h001, {8'h00, s[b]});
    endtask : poll

    // Outside host: clocks only inside a frame, one per bit
    task automatic frame(input int n);
        #37;
        repeat (n) begin
            tb_ck = ~pol;
            #80 tb_ck = pol;
            #80;
        end
    endtask : frame

    function automatic logic [7:0] bt(input int i);
        bt = 8'h00;
        bt[i] = 1'b1;
    endfunction : bt

    // Peer result reduced to the character width
    function automatic logic [8:0] nrm(input logic [8:0] g, input logic nine);
        nrm = nine ? g : {1'b0, g[8:1]};
    endfunction : nrm

    task automatic load(input logic [8:0] w);
        p_w = w;
        p_ld = 1'b1;
        #1 p_ld = 1'b0;
    endtask : load

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        err_count++;
        end_sim();
    end

    initial begin
        logic [8:0] x;
        logic [8:0] y;
        logic [7:0] r;
        realtime t0;
        void'($urandom(48199));
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        rd(A_CTRL, r);
        chk("reset ctrl", 9'h000, {1'b0, r});
        rd(3'h7, r);
        chk("unmapped", 9'h000, {1'b0, r});
        chk("idle enables", 9'h000, {7'h00, ck_oe, dt_oe});
        $display("test reset done");

        // Host transmit, both polarities, queued second word
        for (int p = 0; p < 2; p++) begin
            pol = p[0];
            tb_ck = pol;
            x = 9'($urandom);
            y = {x[8], 8'($urandom)};
            wr(A_DIVL, 8'h03);
            wr(A_CTRL2, {7'h00, x[8]});
            wr(A_CTRL, bt(C_EN) | bt(C_HOST) | bt(C_TRANSMIT_ENABLE) | (p ? bt(C_POL) | bt(C_TX9) : 8'h00));
            @(posedge clk);
            #1 chk("tx enables", 9'h003, {7'h00, ck_oe, dt_oe});
            ntr = 0;
            wr(A_TXD, x[7:0]);
            wr(A_TXD, y[7:0]);
            poll(S_TXE);
            chk("tx first", p ? x : {1'b0, x[7:0]}, nrm(got, p[0]));
            poll(S_IDLE);
            chk("tx second", p ? y : {1'b0, y[7:0]}, nrm(got, p[0]));
            chk("tx clocks", 9'(p ? 18 : 16), 9'(ntr));
            chk("clock idle", {8'h00, pol}, {8'h00, ck});
            $display("test host tx %0d done", p);
        end

        // Host single receive, nine bits
        pol = 1'b0;
        tb_ck = 1'b0;
        wr(A_CTRL, bt(C_EN) | bt(C_HOST) | bt(C_RX9));
        // Wide divisor: half period is the 16-bit divisor plus one; then abort
        wr(A_DIVL, 8'h00);
        wr(A_DIVH, 8'h01);
        wr(A_CTRL2, bt(C2_WIDE));
        wr(A_CTRL, bt(C_EN) | bt(C_HOST) | bt(C_RX9) | bt(C_SINGLE_RECEIVE_ENABLE));
        @(ck) t0 = $realtime;
        @(ck) chk("wide half period", 9'h101, 9'(int'(($realtime - t0) / 5.0)));
        wr(A_CTRL, bt(C_EN) | bt(C_HOST) | bt(C_RX9));
        rd(A_STAT, r);
        chk("abort discards", 9'h002, {7'h00, r[S_IDLE], r[S_RXF]});
        wr(A_CTRL2, 8'h00);
        wr(A_DIVL, 8'h03);
        $display("test wide divisor done");
        load(9'($urandom));
        p_drv = 1'b1;
        ntr = 0;
        wr(A_CTRL, bt(C_EN) | bt(C_HOST) | bt(C_RX9) | bt(C_SINGLE_RECEIVE_ENABLE));
        @(posedge clk);
        #1 chk("rx enables", 9'h002, {7'h00, ck_oe, dt_oe});
        poll(S_RXF);
        rd(A_STAT, r);
        chk("ninth bit", {8'h00, p_w[8]}, {8'h00, r[S_RECEIVE_NINTH_BIT]});
        rd(A_RXD, r);
        chk("rx byte", {1'b0, p_w[7:0]}, {1'b0, r});
        rd(A_CTRL, r);
        chk("single clear", 9'h000, {8'h00, r[C_SINGLE_RECEIVE_ENABLE]});
        chk("rx clocks", 9'd9, 9'(ntr));
        $display("test host rx done");

        // Continuous receive until the FIFO overruns
        load({1'b0, 8'($urandom)});
        wr(A_CTRL, bt(C_EN) | bt(C_HOST) | bt(C_CONTINUOUS_RECEIVE_ENABLE));
        poll(S_OVERRUN_FLAG);
        rd(A_RXD, r);
        chk("kept first", {1'b0, p_w[7:0]}, {1'b0, r});
        rd(A_RXD, r);
        chk("kept second", 9'h000, {1'b0, r});
        rd(A_STAT, r);
        chk("blocked", 9'h002, {7'h00, r[S_OVERRUN_FLAG], r[S_RXF]});
        wr(A_CTRL, bt(C_EN) | bt(C_HOST));
        rd(A_STAT, r);
        chk("overrun clear", 9'h000, {8'h00, r[S_OVERRUN_FLAG]});
        $display("test overrun done");

        // Client receive then transmit, clock from outside
        pol = 1'b1;
        tb_ck = 1'b1;
        wr(A_CTRL, bt(C_EN) | bt(C_POL) | bt(C_CONTINUOUS_RECEIVE_ENABLE));
        @(posedge clk);
        #1 chk("client enables", 9'h000, {7'h00, ck_oe, dt_oe});
        load({1'b0, 8'($urandom)});
        frame(8);
        poll(S_RXF);
        rd(A_RXD, r);
        chk("client rx", {1'b0, p_w[7:0]}, {1'b0, r});
        p_drv = 1'b0;
        x = 9'($urandom);
        wr(A_CTRL, bt(C_EN) | bt(C_POL) | bt(C_TRANSMIT_ENABLE));
        wr(A_TXD, x[7:0]);
        chk("client drives", 9'h001, {7'h00, ck_oe, dt_oe});
        frame(8);
        chk("client tx", {1'b0, x[7:0]}, nrm(got, 1'b0));
        $display("test client done");
        end_sim();
    end
endmodule : usy_top_tb

`default_nettype wire
